// File: core/sru_pkg.sv
// Shared constants and types for the shift, rotate and bit unit
package sru_pkg;

    // Register byte offsets on APB
    localparam logic [7:0] SRU_DEST_OFS   = 8'h00;
    localparam logic [7:0] SRU_FILL_OFS   = 8'h04;
    localparam logic [7:0] SRU_COUNT_OFS  = 8'h08;
    localparam logic [7:0] SRU_CTRL_OFS   = 8'h0c;
    localparam logic [7:0] SRU_FLAGS_OFS  = 8'h10;
    localparam logic [7:0] SRU_RESULT_OFS = 8'h14;
    localparam logic [7:0] SRU_STATUS_OFS = 8'h18;

    // Reset values
    localparam logic [31:0] SRU_DATA_RST  = 32'h0000_0000;
    localparam logic [4:0]  SRU_COUNT_RST = 5'h00;
    localparam logic [15:0] SRU_CTRL_RST  = 16'h0000;

    // Control register field positions
    localparam int SRU_CTRL_OP_LSB   = 0;
    localparam int SRU_CTRL_SIZE_LSB = 8;
    localparam int SRU_CTRL_COND_LSB = 12;

    // Status flag word bit positions
    localparam int SRU_CARRY_POS    = 0;
    localparam int SRU_PARITY_POS   = 2;
    localparam int SRU_ZERO_POS     = 6;
    localparam int SRU_SIGN_POS     = 7;
    localparam int SRU_OVERFLOW_POS = 11;

    // Status register bit positions
    localparam int SRU_STAT_ILLEGAL_POS = 0;
    localparam int SRU_STAT_NOBIT_POS   = 1;

    // Operation select, codes follow declaration order from zero
    typedef enum logic [4:0] {
        OP_ARITH_LEFT_SHIFT, OP_LOGICAL_LEFT_SHIFT, OP_LOGICAL_RIGHT_SHIFT,
        OP_ARITH_RIGHT_SHIFT, OP_DOUBLE_LEFT_SHIFT, OP_DOUBLE_RIGHT_SHIFT,
        OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_CARRY_ROTATE_LEFT,
        OP_CARRY_ROTATE_RIGHT, OP_BIT_PROBE, OP_BIT_PROBE_SET,
        OP_BIT_PROBE_CLEAR, OP_BIT_PROBE_INVERT, OP_LOWEST_SET_BIT_SCAN,
        OP_HIGHEST_SET_BIT_SCAN, OP_FLAG_TO_BYTE, OP_LOGIC_TEST
    } sru_op_t;

    // Operand size
    typedef enum logic [1:0] {
        SZ_BYTE, SZ_WORD, SZ_DWORD, SZ_BAD
    } sru_size_t;

    // Flag-to-byte conditions, overflow_to_byte first
    typedef enum logic [3:0] {
        CC_OVERFLOW, CC_NO_OVERFLOW, CC_BELOW, CC_NOT_BELOW,
        CC_ZERO, CC_NOT_ZERO, CC_BELOW_EQ, CC_ABOVE,
        CC_SIGN, CC_NO_SIGN, CC_PARITY, CC_NO_PARITY,
        CC_LESS, CC_NOT_LESS, CC_LESS_EQ, CC_GREATER
    } sru_cond_t;

    // Status flags travel together
    typedef struct packed {
        logic overflow_flag;
        logic sign_flag;
        logic zero_flag;
        logic parity_flag;
        logic carry_flag;
    } sru_flags_t;

endpackage : sru_pkg

// File: core/sru_unit.sv
// Shift, rotate, bit probe, bit scan, flag-to-byte and test unit with APB registers
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module sru_unit
(
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR
);
    import sru_pkg::*;

    // Operand width in bits for a size code
    function automatic int width_of(input sru_size_t sz);
        case (sz)
            SZ_BYTE:  width_of = 8;
            SZ_WORD:  width_of = 16;
            default:  width_of = 32;
        endcase
    endfunction : width_of

    // Mask of the low n bits, n up to 33
    function automatic logic [63:0] low_mask(input int n);
        low_mask = (64'h1 << n) - 64'h1;
    endfunction : low_mask

    // Software-visible state and the internal launch pulse run
    logic [31:0] dest;
    logic [31:0] fill;
    logic [4:0]  count;
    logic [15:0] ctrl;
    sru_flags_t  flags;
    logic [31:0] result;
    logic        illegal;
    logic        nobit;
    logic        run;

    // Bus phase decode
    wire         setup_cyc  = PSEL && !PENABLE;
    wire         access_cyc = PSEL && PENABLE && PREADY;
    wire         wr_cyc     = access_cyc && PWRITE;
    wire         hit_dest   = PADDR == SRU_DEST_OFS;
    wire         hit_fill   = PADDR == SRU_FILL_OFS;
    wire         hit_count  = PADDR == SRU_COUNT_OFS;
    wire         hit_ctrl   = PADDR == SRU_CTRL_OFS;
    wire         hit_flags  = PADDR == SRU_FLAGS_OFS;
    wire         hit_result = PADDR == SRU_RESULT_OFS;
    wire         hit_status = PADDR == SRU_STATUS_OFS;

    // Control fields
    wire sru_op_t   op   = sru_op_t'(ctrl[SRU_CTRL_OP_LSB +: 5]);
    wire sru_size_t size = sru_size_t'(ctrl[SRU_CTRL_SIZE_LSB +: 2]);
    wire sru_cond_t cond = sru_cond_t'(ctrl[SRU_CTRL_COND_LSB +: 4]);

    // Flag word packing
    logic [31:0] flag_word;
    always_comb
    begin
        flag_word                   = 32'h0;
        flag_word[SRU_CARRY_POS]    = flags.carry_flag;
        flag_word[SRU_PARITY_POS]   = flags.parity_flag;
        flag_word[SRU_ZERO_POS]     = flags.zero_flag;
        flag_word[SRU_SIGN_POS]     = flags.sign_flag;
        flag_word[SRU_OVERFLOW_POS] = flags.overflow_flag;
    end

    // Read mux and unmapped detection
    logic [31:0] rd_data;
    logic        rd_miss;
    always_comb
    begin
        rd_miss = 1'b0;
        if (hit_dest)
            rd_data = dest;
        else if (hit_fill)
            rd_data = fill;
        else if (hit_count)
            rd_data = {27'h0, count};
        else if (hit_ctrl)
            rd_data = {16'h0, ctrl};
        else if (hit_flags)
            rd_data = flag_word;
        else if (hit_result)
            rd_data = result;
        else if (hit_status)
            rd_data = {30'h0, nobit, illegal};
        else
        begin
            rd_data = 32'h0;
            rd_miss = 1'b1;
        end
    end

    // Result store is read only, so a write there is refused too
    wire wr_refused = rd_miss || hit_result || hit_status;

    // Datapath working values
    logic [31:0] alu_res;
    logic        alu_res_we;
    sru_flags_t  alu_flags;
    logic        alu_bad;
    logic        alu_nobit;

    // The whole operation is combinational from the operand registers
    always_comb
    begin
        int          w, n, r;
        logic [31:0] m, a, b, sa;
        logic [63:0] e, rot;
        logic [95:0] t;
        logic        cc, setszp;
        w          = width_of(size);
        n          = w + 1;
        r          = 0;
        m          = 32'(low_mask(w));
        a          = dest & m;
        b          = fill & m;
        sa         = a;
        e          = 64'h0;
        rot        = 64'h0;
        t          = 96'h0;
        cc         = 1'b0;
        setszp     = 1'b0;
        alu_res    = dest;
        alu_res_we = 1'b0;
        alu_flags  = flags;
        alu_bad    = 1'b0;
        alu_nobit  = 1'b0;
        if (size == SZ_BAD)
            alu_bad = 1'b1;
        else
        begin
            case (op)
                // Shifts on the selected width only; count 0 changes nothing
                OP_ARITH_LEFT_SHIFT, OP_LOGICAL_LEFT_SHIFT:
                begin
                    t = 96'(a) << count;
                    alu_res = t[31:0] & m;
                    alu_flags.carry_flag = t[w];
                    alu_flags.overflow_flag = alu_res[w-1] ^ t[w];
                    setszp = 1'b1;
                end
                OP_LOGICAL_RIGHT_SHIFT:
                begin
                    t = {32'h0, a, 32'h0} >> count;
                    alu_res = t[63:32];
                    alu_flags.carry_flag = t[31];
                    alu_flags.overflow_flag = a[w-1];
                    setszp = 1'b1;
                end
                OP_ARITH_RIGHT_SHIFT:
                begin
                    sa = 32'($signed(a << (32 - w)) >>> (32 - w));
                    t = {{32{sa[31]}}, sa, 32'h0} >> count;
                    alu_res = t[63:32] & m;
                    alu_flags.carry_flag = t[31];
                    alu_flags.overflow_flag = 1'b0;
                    setszp = 1'b1;
                end
                // Left: destination above fill; right: fill above destination; the last bit shifted out goes into carry
                OP_DOUBLE_LEFT_SHIFT:
                begin
                    alu_bad = size == SZ_BYTE;
                    t = ((96'(a) << w) | 96'(b)) << count;
                    alu_res = 32'(t >> w) & m;
                    alu_flags.carry_flag = t[2*w];
                    alu_flags.overflow_flag = alu_res[w-1] ^ a[w-1];
                    setszp = 1'b1;
                end
                OP_DOUBLE_RIGHT_SHIFT:
                begin
                    alu_bad = size == SZ_BYTE;
                    t = ((((96'(b) << w) | 96'(a))) << 32) >> count;
                    alu_res = t[63:32] & m;
                    alu_flags.carry_flag = t[31];
                    alu_flags.overflow_flag = alu_res[w-1] ^ a[w-1];
                    setszp = 1'b1;
                end
                // Width is a power of two, so the modulo is a mask
                OP_ROTATE_LEFT:
                begin
                    r = int'(count) & (w - 1);
                    t = 96'(a) << r;
                    alu_res = (t[31:0] | 32'(t >> w)) & m;
                    alu_flags.carry_flag = alu_res[0];
                end
                OP_ROTATE_RIGHT:
                begin
                    r = int'(count) & (w - 1);
                    t = {32'h0, a, 32'h0} >> r;
                    alu_res = (t[63:32] | (t[31:0] >> (32 - w))) & m;
                    alu_flags.carry_flag = alu_res[w-1];
                end
                // Carry sits at bit w of an n-bit ring; right is left by n-r
                OP_CARRY_ROTATE_LEFT, OP_CARRY_ROTATE_RIGHT:
                begin
                    r = int'(count) % n;
                    if (op == OP_CARRY_ROTATE_RIGHT)
                        r = n - r;
                    e = (64'(flags.carry_flag) << w) | 64'(a);
                    t = 96'(e) << r;
                    rot = (t[63:0] | 64'(t >> n)) & low_mask(n);
                    alu_res = rot[31:0] & m;
                    alu_flags.carry_flag = rot[w];
                end
                // Probe: carry takes the old bit, then set, clear and invert modify the bit
                OP_BIT_PROBE, OP_BIT_PROBE_SET, OP_BIT_PROBE_CLEAR, OP_BIT_PROBE_INVERT:
                begin
                    r = int'(count) & (w - 1);
                    alu_flags.carry_flag = a[r];
                    alu_res = a;
                    if (op == OP_BIT_PROBE_SET)
                        alu_res[r] = 1'b1;
                    else if (op == OP_BIT_PROBE_CLEAR)
                        alu_res[r] = 1'b0;
                    else if (op == OP_BIT_PROBE_INVERT)
                        alu_res[r] = ~a[r];
                    alu_res_we = op != OP_BIT_PROBE;
                end
                // Later hits overwrite, so loop direction picks the end
                OP_LOWEST_SET_BIT_SCAN:
                begin
                    for (int i = 31; i >= 0; i--)
                        if (b[i])
                            alu_res = 32'(i);
                    alu_nobit = b == 32'h0;
                    alu_flags.zero_flag = alu_nobit;
                    alu_res_we = !alu_nobit;
                end
                OP_HIGHEST_SET_BIT_SCAN:
                begin
                    for (int i = 0; i < 32; i++)
                        if (b[i])
                            alu_res = 32'(i);
                    alu_nobit = b == 32'h0;
                    alu_flags.zero_flag = alu_nobit;
                    alu_res_we = !alu_nobit;
                end
                // Condition pairs: even code tests, odd code inverts
                OP_FLAG_TO_BYTE:
                begin
                    case (cond[3:1])
                        3'h0: cc = flags.overflow_flag;
                        3'h1: cc = flags.carry_flag;
                        3'h2: cc = flags.zero_flag;
                        3'h3: cc = flags.carry_flag | flags.zero_flag;
                        3'h4: cc = flags.sign_flag;
                        3'h5: cc = flags.parity_flag;
                        3'h6: cc = flags.sign_flag ^ flags.overflow_flag;
                        default: cc = (flags.sign_flag ^ flags.overflow_flag) | flags.zero_flag;
                    endcase
                    alu_res = {dest[31:8], 7'h0, cc ^ cond[0]};
                    alu_res_we = 1'b1;
                end
                OP_LOGIC_TEST:
                begin
                    alu_res = a & b;
                    alu_flags.carry_flag = 1'b0;
                    alu_flags.overflow_flag = 1'b0;
                    setszp = 1'b1;
                end
                default: alu_bad = 1'b1;
            endcase
            // Shifts write back only on a non-zero count; test never does
            if (op <= OP_DOUBLE_RIGHT_SHIFT)
            begin
                alu_res_we = count != 5'h0;
                if (count != 5'h1)
                    alu_flags.overflow_flag = flags.overflow_flag;
            end
            if (op >= OP_ROTATE_LEFT && op <= OP_CARRY_ROTATE_RIGHT)
                alu_res_we = count != 5'h0;
            if (setszp)
            begin
                alu_flags.sign_flag = alu_res[w-1];
                alu_flags.zero_flag = (alu_res & m) == 32'h0;
                alu_flags.parity_flag = ~^alu_res[7:0];
            end
            if (op <= OP_CARRY_ROTATE_RIGHT && count == 5'h0)
                alu_flags = flags;
        end
        if (alu_bad)
        begin
            alu_res_we = 1'b0;
            alu_flags = flags;
        end
    end

    // Bus answer registered in setup, so every access has zero wait states
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            PRDATA  <= SRU_DATA_RST;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY  <= setup_cyc;
            PRDATA  <= (setup_cyc && !PWRITE) ? rd_data : SRU_DATA_RST;
            PSLVERR <= setup_cyc && (PWRITE ? wr_refused : rd_miss);
        end
    end

    // Operand and control registers; a control write launches one operation
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            dest  <= SRU_DATA_RST;
            fill  <= SRU_DATA_RST;
            count <= SRU_COUNT_RST;
            ctrl  <= SRU_CTRL_RST;
            run   <= 1'b0;
        end
        else
        begin
            run <= wr_cyc && hit_ctrl;
            if (wr_cyc && hit_dest)
                dest <= PWDATA;
            else if (run && alu_res_we)
                dest <= alu_res;
            if (wr_cyc && hit_fill)
                fill <= PWDATA;
            if (wr_cyc && hit_count)
                count <= PWDATA[4:0];
            if (wr_cyc && hit_ctrl)
                ctrl <= PWDATA[15:0];
        end
    end

    // Flags and outcome; the operation updates them the cycle after launch
    always_ff @(posedge MCLK)
    begin
        if (!RST_N)
        begin
            flags   <= '0;
            result  <= SRU_DATA_RST;
            illegal <= 1'b0;
            nobit   <= 1'b0;
        end
        else if (run)
        begin
            flags   <= alu_flags;
            result  <= alu_res_we ? alu_res : dest;
            illegal <= alu_bad;
            nobit   <= alu_nobit;
        end
        else if (wr_cyc && hit_flags)
        begin
            flags.carry_flag    <= PWDATA[SRU_CARRY_POS];
            flags.parity_flag   <= PWDATA[SRU_PARITY_POS];
            flags.zero_flag     <= PWDATA[SRU_ZERO_POS];
            flags.sign_flag     <= PWDATA[SRU_SIGN_POS];
            flags.overflow_flag <= PWDATA[SRU_OVERFLOW_POS];
        end
    end

endmodule : sru_unit

// File: tb/sru_apb_host.sv
// APB master standing in for the processor's decode and register file
`timescale 1ns/1ps
module sru_apb_host
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic        wr,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    output logic             done,
    output logic      [31:0] rdata,
    output logic             err,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // Setup, access held until pready, then release with inverted buses
    always_ff @(posedge mclk)
    begin
        done <= 1'b0;
        if (!rst_n)
        begin
            {psel, penable, pwrite, paddr, pwdata, rdata, err} <= '0;
        end
        else if (psel && penable && pready)
        begin
            psel <= 1'b0;
            penable <= 1'b0;
            rdata <= prdata;
            err <= pslverr;
            done <= 1'b1;
            paddr <= ~paddr;  // Stale address must not look valid
            pwdata <= ~pwdata;
        end
        else if (psel)
            penable <= 1'b1;
        else if (start)
        begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= addr;
            pwdata <= wdata;
        end
    end
endmodule : sru_apb_host

// File: tb/sru_assertions.sv
// Bus handshake checks on the unit's APB slave port
`timescale 1ns/1ps
module sru_assertions
(
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [31:0] PRDATA,
    input  wire logic        PREADY,
    input  wire logic        PSLVERR
);
    import sru_pkg::*;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    // Address classes; unaligned or past the last register is unmapped
    wire logic acc = PSEL && PENABLE && PREADY;
    wire logic mapped = (PADDR[1:0] == 2'b00) && (PADDR <= SRU_STATUS_OFS);
    wire logic ro = (PADDR == SRU_RESULT_OFS) || (PADDR == SRU_STATUS_OFS);
    a_ready_pulse: assert property ($rose(PREADY) |=> $fell(PREADY)) // One-cycle answer
        else $error("pready too long");
    a_ready_phase: assert property (PREADY |-> PSEL && PENABLE) // Only in access
        else $error("stray pready");
    a_zero_wait: assert property (PSEL && !PENABLE |=> PREADY) // No wait states
        else $error("pready late after setup");
    a_rdata_quiet: assert property (!PREADY |-> PRDATA == 32'h0) // Bus quiet
        else $error("prdata not idle");
    a_err_timing: assert property (PSLVERR |-> PREADY) // Error rides the answer
        else $error("pslverr without pready");
    a_unmapped_err: assert property (acc && !mapped |-> PSLVERR && PRDATA == 32'h0) // Refusal
        else $error("unmapped access not refused");
    a_ro_refused: assert property (acc && PWRITE && ro |-> PSLVERR) // Read-only places
        else $error("read-only write accepted");
    a_mapped_ok: assert property (acc && mapped && !(PWRITE && ro) |-> !PSLVERR) // Legal access
        else $error("legal access refused");
    a_count_width: assert property (acc && !PWRITE && PADDR == SRU_COUNT_OFS |-> PRDATA[31:5] == 27'h0)
        else $error("count wider than five bits");
endmodule : sru_assertions

// File: tb/sru_unit_tb.sv
// Self-checking bench for the shift, rotate and bit unit
`timescale 1ns/1ps
bind sru_unit sru_assertions u_chk (.*);
module sru_unit_tb;
    import sru_pkg::*;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    localparam logic [31:0] NONE = 32'h0;
    logic        mclk, rst_n, start, wr, done, err, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  addr, paddr;
    logic [31:0] wdata, rdata, pwdata, prdata;
    int          n_mismatch;
    int          comparisons;
    int          cnt[4] = '{0, 1, 17, 31};
    sru_apb_host u_host (.*);
    sru_unit dut (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
    task automatic finish_test;
        if (n_mismatch == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // One transfer through the host; bounded wait for its completion
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        start <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        start <= 1'b0;
        repeat (20)
        begin
            @(posedge mclk);
            if (done === 1'b1)
                break;
        end
        check("transfer done", 32'h1, {31'h0, done});
    endtask : bus
    // Load operands, launch, then compare result and optionally carry
    task automatic run(input logic [4:0] op, input logic [1:0] sz, input logic [31:0] d,
        input logic [31:0] f, input logic [4:0] c, input logic [31:0] fl,
        input logic [31:0] er, input logic [31:0] mk, input logic [1:0] ecf,
        input logic [3:0] cc = 4'h0);
        bus(1'b1, SRU_DEST_OFS, d);
        bus(1'b1, SRU_FILL_OFS, f);
        bus(1'b1, SRU_COUNT_OFS, {27'h0, c});
        bus(1'b1, SRU_FLAGS_OFS, fl);
        bus(1'b1, SRU_CTRL_OFS, {16'h0, cc, 2'h0, sz, 3'h0, op});
        bus(1'b0, SRU_RESULT_OFS, NONE);
        check("result", er & mk, rdata & mk);
        bus(1'b0, SRU_FLAGS_OFS, NONE);
        if (ecf[1])
            check("carry_flag", {31'h0, ecf[0]}, {31'h0, rdata[SRU_CARRY_POS]});
    endtask : run
    task automatic t_regs;
        for (int a = 0; a <= 'h18; a += 4)
        begin
            bus(1'b0, 8'(a), NONE);
            check("reset value", NONE, rdata);
        end
        bus(1'b0, 8'h1c, NONE);
        check("unmapped error", 32'h1, {31'h0, err});
        bus(1'b1, SRU_RESULT_OFS, 32'h5555_aaaa);
        check("read-only error", 32'h1, {31'h0, err});
        bus(1'b1, SRU_COUNT_OFS, ALL);
        bus(1'b0, SRU_COUNT_OFS, NONE);
        check("count", 32'h1f, rdata);
    endtask : t_regs
    task automatic t_shift;
        logic [31:0] d, r;
        logic        cf;
        int          c, o;
        d = 32'h9234_56f1;
        for (int i = 0; i < 12; i++)
        begin
            o = i / 3;
            c = (i % 3 == 2) ? 31 : 1 + 12 * (i % 3);
            r = d >> c;
            cf = d[c - 1];
            if (o < 2)
                {cf, r} = {d[32 - c], d << c};
            if (o == 3)
                r = $signed(d) >>> c;
            run(5'(o), SZ_DWORD, d, NONE, 5'(c), NONE, r, ALL, {1'b1, cf});
        end
        // Byte width: only the low eight bits take part
        run(OP_LOGICAL_LEFT_SHIFT, SZ_BYTE, 32'h1234_5681, NONE, 5'd1, NONE, 32'h02, 32'hff, 2'b11);
        run(OP_ARITH_RIGHT_SHIFT, SZ_BYTE, 32'h1234_5681, NONE, 5'd2, 32'h1, 32'he0, 32'hff, 2'b10);
    endtask : t_shift
    task automatic t_double;
        logic [31:0] d, f, r;
        logic        cf;
        int          c;
        d = 32'h8123_4567;
        f = 32'hfedc_ba98;
        for (int i = 0; i < 8; i++)
        begin
            c = cnt[i % 4];
            {cf, r} = {1'b1, d};
            if (c != 0 && i < 4)
                {cf, r} = {d[32 - c], (d << c) | (f >> (32 - c))};
            if (c != 0 && i >= 4)
                {cf, r} = {d[c - 1], (d >> c) | (f << (32 - c))};
            run(5'(4 + i / 4), SZ_DWORD, d, f, 5'(c), 32'h1, r, ALL, {1'b1, cf});
        end
        run(OP_DOUBLE_LEFT_SHIFT, SZ_WORD, 32'h1234, 32'habcd, 5'd4, NONE, 32'h234a, 32'hffff, 2'b11);
    endtask : t_double
    task automatic t_rotate;
        logic [31:0] d, r;
        logic [32:0] x, y;
        logic        cf;
        int          c;
        d = 32'h8421_0f03;
        x = {1'b1, d};
        for (int i = 0; i < 16; i++)
        begin
            c = cnt[i % 4];
            r = (i < 4) ? (d << c) | (d >> (32 - c)) : (d >> c) | (d << (32 - c));
            cf = (i < 4) ? r[0] : r[31];
            y = (i < 12) ? (x << c) | (x >> (33 - c)) : (x >> c) | (x << (33 - c));
            if (i >= 8)
                {cf, r} = y;
            if (c == 0)
                cf = 1'b1;
            run(5'(6 + i / 4), SZ_DWORD, d, NONE, 5'(c), 32'h1,
                r, ALL, {1'b1, cf});
        end
    endtask : t_rotate
    task automatic t_probe;
        logic [31:0] d, m, r;
        int          c;
        d = 32'h8000_0021;
        for (int i = 0; i < 12; i++)
        begin
            c = (i % 3 == 2) ? 31 : 6 * (i % 3);
            m = 32'h1 << c;
            r = (i < 3) ? d : (i < 6) ? d | m : (i < 9) ? d & ~m : d ^ m;
            run(5'(10 + i / 3), SZ_DWORD, d, NONE, 5'(c), {31'h0, ~d[c]},
                r, ALL, {1'b1, d[c]});
        end
    endtask : t_probe
    task automatic t_scan;
        logic [31:0] src[3];
        int          lo, hi;
        src = '{32'h0010_0100, 32'h1, 32'h8000_0000};
        foreach (src[i])
        begin
            lo = -1;
            for (int b = 0; b < 32; b++)
                if (src[i][b])
                begin
                    hi = b;
                    lo = (lo < 0) ? b : lo;
                end
            run(OP_LOWEST_SET_BIT_SCAN, SZ_DWORD, ALL, src[i], 5'd0, NONE, 32'(lo), ALL, 2'b00);
            run(OP_HIGHEST_SET_BIT_SCAN, SZ_DWORD, ALL, src[i], 5'd0, NONE, 32'(hi), ALL, 2'b00);
        end
        // Empty source leaves the destination alone and flags it
        run(OP_LOWEST_SET_BIT_SCAN, SZ_DWORD, 32'h5a5a_5a5a, NONE, 5'd0, NONE, 32'h5a5a_5a5a, ALL, 2'b00);
        check("zero_flag", 32'h1, {31'h0, rdata[SRU_ZERO_POS]});
        bus(1'b0, SRU_STATUS_OFS, NONE);
        check("empty scan", 32'h1, {31'h0, rdata[SRU_STAT_NOBIT_POS]});
    endtask : t_scan
    task automatic t_cond;
        logic [31:0] fl[3], v;
        logic        e;
        fl = '{32'h0000_0801, 32'h0000_00c4, 32'h0000_0880};
        foreach (fl[j])
            for (int cc = 0; cc < 16; cc++)
            begin
                v = fl[j];
                case (cc / 2)
                    0: e = v[SRU_OVERFLOW_POS];
                    1: e = v[SRU_CARRY_POS];
                    2: e = v[SRU_ZERO_POS];
                    3: e = v[SRU_CARRY_POS] | v[SRU_ZERO_POS];
                    4: e = v[SRU_SIGN_POS];
                    5: e = v[SRU_PARITY_POS];
                    6: e = v[SRU_SIGN_POS] ^ v[SRU_OVERFLOW_POS];
                    default: e = (v[SRU_SIGN_POS] ^ v[SRU_OVERFLOW_POS]) | v[SRU_ZERO_POS];
                endcase
                run(OP_FLAG_TO_BYTE, SZ_BYTE, 32'habcd_ef55, NONE, 5'd0, v,
                    {31'h0, e ^ cc[0]}, 32'hff, 2'b00, 4'(cc));
            end
    endtask : t_cond
    task automatic t_test;
        logic [31:0] d[3], f[3], a;
        d = '{32'h0000_f0f0, 32'h8000_0000, 32'h0f0f_0f0f};
        f = '{32'h8000_00f0, 32'h8000_0001, 32'hf0f0_f0f0};
        foreach (d[i])
        begin
            a = d[i] & f[i];
            run(OP_LOGIC_TEST, SZ_DWORD, d[i], f[i], 5'd0, 32'h0000_08c1, d[i], ALL, 2'b10);
            check("sign_flag", {31'h0, a[31]}, {31'h0, rdata[SRU_SIGN_POS]});
            check("zero_flag", {31'h0, a == NONE}, {31'h0, rdata[SRU_ZERO_POS]});
        end
    endtask : t_test
    // Bad code, bad size and a byte double shift all change nothing
    task automatic t_illegal;
        for (int i = 0; i < 3; i++)
        begin
            run((i == 0) ? 5'd18 : 5'(5 * (i - 1)), (i == 1) ? SZ_BAD : (i == 2) ? SZ_BYTE : SZ_DWORD,
                32'h1357_9bdf, ALL, 5'd4, 32'h1, 32'h1357_9bdf, ALL, 2'b11);
            bus(1'b0, SRU_STATUS_OFS, NONE);
            check("illegal", 32'h1, {31'h0, rdata[SRU_STAT_ILLEGAL_POS]});
        end
    endtask : t_illegal
    // Free-running clock at 20 MHz
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Far above the length of the sequence
    initial
    begin
        #(50 * 40000);
        n_mismatch++;
        finish_test();
    end
    initial
    begin
        {rst_n, start, wr, addr, wdata} = '0;
        n_mismatch = 0;
        comparisons = 0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_shift();
        t_double();
        t_rotate();
        t_probe();
        t_scan();
        t_cond();
        t_test();
        t_illegal();
        finish_test();
    end
endmodule : sru_unit_tb
